// >>> rtl/thermal_fan_consts.svh
`ifndef THERMAL_FAN_CONSTS_SVH
`define THERMAL_FAN_CONSTS_SVH

// register indexes
`define IDX_TEMP_A 8'h00
`define IDX_TEMP_B 8'h01
`define IDX_STATUS 8'h02
`define IDX_CONFIG 8'h03
`define IDX_CONV_RATE 8'h04
`define IDX_HIGH_LIM 8'h05
`define IDX_LOW_LIM 8'h06
`define IDX_FORCE_A 8'h07
`define IDX_RELEASE_A 8'h08
`define IDX_FORCE_B 8'h09
`define IDX_RELEASE_B 8'h0a
`define IDX_CRIT_A 8'h0b
`define IDX_CRIT_B 8'h0c
`define IDX_SHUT_CFG 8'h0d
`define IDX_ONE_SHOT 8'h0f
`define IDX_FAN_TARGET 8'h10
`define IDX_FAN_MEAS 8'h11
`define IDX_FAN_HEALTH 8'h12

// reset values
`define RST_POINTER 8'h00
`define RST_CONFIG 8'h00
`define RST_CONV_RATE 8'h02
`define RST_HIGH_LIM 8'h7f
`define RST_LOW_LIM 8'h80
`define RST_FORCE 8'h46
`define RST_RELEASE 8'h3c
`define RST_CRIT 8'h7f
`define RST_SHUT_CFG 8'h12
`define RST_FAN_TARGET 8'hff
`define RST_FAN_MEAS 8'hff
`define RST_FAN_HEALTH 8'h02

// field positions
`define CFG_STANDBY_BIT 6
`define CFG_DETECT_BIT 5
`define SHUT_FILTER_BIT 4
`define ST_BUSY 7
`define ST_HIGH_B 6
`define ST_LOW_B 5
`define ST_HIGH_A 4
`define ST_LOW_A 3
`define ST_OPEN 2
`define ST_FAN_FAIL 0
`define HEALTH_OFF 0
`define HEALTH_SLOW 1

// bus addresses (7-bit) and alert reply byte
`define DEV_ADDR 7'h3d
`define ARA_ADDR 7'h0c
`define ARA_REPLY 8'h7a

// fan measurement
`define TACH_SAT 8'hff
`define SAT_RUN_LIMIT 4'h8
`define OFF_TARGET_PCT 20
`define OFF_TARGET_MUL (100 / `OFF_TARGET_PCT)
`define FAULT_MAX 5'h10

// timing
`define CLK_KHZ 25000
`define CONV_TIME_MS 125
`define CONV_CYCLES (`CONV_TIME_MS * `CLK_KHZ)
`define RATE_SLOWEST_MS 16000
`define RATE_BASE_CYCLES (`RATE_SLOWEST_MS * `CLK_KHZ)
`define REF_HZ 32768
`define STALL_TIME_MS 500
`define STALL_REF_CYCLES (`STALL_TIME_MS * `REF_HZ / 1000)

`endif

// >>> rtl/thermal_fan_pkg.sv
package thermal_fan_pkg;
	// remote temperature, two's complement degrees
	typedef logic signed [7:0] temp_t;
	// serial slave states, gray along the usual path
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ADDR = 3'h1,
		S_ACK_ADDR = 3'h3,
		S_RX = 3'h2,
		S_ACK_RX = 3'h6,
		S_TX = 3'h7,
		S_MACK = 3'h5
	} smb_state_t;
	// conversion scheduler states
	typedef enum logic {
		CONV_IDLE = 1'b0,
		CONV_RUN = 1'b1
	} conv_state_t;
endpackage

// >>> rtl/fan_tach_meter.sv
`timescale 1ns/1ps
`include "thermal_fan_consts.svh"
module fan_tach_meter #(
	parameter int STALL_CYCLES = `STALL_REF_CYCLES
) (
	// reference clock and reset from system domain
	input wire logic ref_clk,
	input wire logic srst,
	// tachometer pin
	input wire logic tach_input,
	// measurement towards system domain
	output logic [7:0] count_out,
	output logic count_tgl,
	output logic stalled
);
	logic rst_meta; // reset synchroniser stage one
	logic ref_rst; // reset in reference domain
	logic [2:0] tach_sh; // two sync stages plus history
	logic [7:0] period_cnt; // reference periods since last pulse
	logic [14:0] stall_cnt; // periods since last transition

	// bring reset into the reference domain
	always_ff @(posedge ref_clk) begin
		rst_meta <= srst;
		ref_rst <= rst_meta;
	end

	// tach pin synchroniser
	always_ff @(posedge ref_clk) begin
		tach_sh <= {tach_sh[1:0], tach_input};
	end

	// period count per pulse, republish saturated value while slow
	always_ff @(posedge ref_clk) begin
		if (ref_rst) begin
			period_cnt <= 8'h00;
			count_out <= `TACH_SAT;
			count_tgl <= 1'b0;
		end else if (tach_sh[1] && !tach_sh[2]) begin
			count_out <= period_cnt;
			count_tgl <= ~count_tgl;
			// the edge cycle is already the first period of the next count
			period_cnt <= 8'h01;
		end else if (period_cnt == `TACH_SAT) begin
			count_out <= `TACH_SAT;
			count_tgl <= ~count_tgl;
			period_cnt <= 8'h01;
		end else begin
			period_cnt <= period_cnt + 8'h01;
		end
	end

	// no-transition watchdog
	always_ff @(posedge ref_clk) begin
		if (ref_rst) begin
			stall_cnt <= 15'h0000;
			stalled <= 1'b0;
		end else begin
			if (tach_sh[1] != tach_sh[2])
				stall_cnt <= 15'h0000;
			else if (stall_cnt < 15'(STALL_CYCLES))
				stall_cnt <= stall_cnt + 15'h0001;
			stalled <= (stall_cnt >= 15'(STALL_CYCLES));
		end
	end
endmodule // fan_tach_meter

// >>> rtl/thermal_fan_supervisor.sv
`timescale 1ns/1ps
`include "thermal_fan_consts.svh"
module thermal_fan_supervisor #(
	parameter int CONV_CYCLES = `CONV_CYCLES,
	parameter int RATE_BASE_CYCLES = `RATE_BASE_CYCLES,
	parameter int STALL_CYCLES = `STALL_REF_CYCLES
) (
	// system clock and reset
	input wire logic clk,
	input wire logic srst,
	// fan reference clock
	input wire logic ref_clk,
	// serial bus pins
	input wire logic smb_clk_in,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe_n,
	// alert pin, open drain, active low
	output logic alert_out,
	output logic alert_oe_n,
	// converter interface
	output logic conv_start,
	output logic conv_busy,
	input thermal_fan_pkg::temp_t remote_diode_a_temp,
	input thermal_fan_pkg::temp_t remote_diode_b_temp,
	input wire logic supply_low,
	input wire logic remote_diode_a_open,
	input wire logic remote_diode_b_open,
	input wire logic remote_diode_a_short,
	input wire logic remote_diode_b_short,
	// fan and shutdown
	input wire logic tach_input,
	output logic [7:0] fan_target_out,
	output logic fan_supply_out,
	output logic thermal_shutdown_out
);
	import thermal_fan_pkg::*;

	logic [6:0] pin_raw; // asynchronous pins
	logic [6:0] pin_meta; // first stage
	logic [6:0] pin_sync; // second stage
	logic scl_d, sda_d; // previous synced bus levels
	logic scl_s, sda_s, low_s; // synced bus and supply levels
	logic [1:0] open_s, short_s; // synced diode faults
	logic scl_rise, scl_fall, start_ev, stop_ev; // bus events
	smb_state_t smb_state; // slave state
	logic [3:0] bit_cnt; // bit position in byte
	logic [7:0] shift_reg; // byte shifter
	logic rw_reg, ara_reg, first_reg, mack_reg, drive_reg; // transfer flags
	logic [7:0] pointer_reg; // command pointer
	logic wr_stb, rd_stb, ara_stb; // one-cycle bus strobes
	logic [7:0] tx_byte, rd_data; // byte to send
	logic [7:0] config_reg, conv_rate_reg, high_reg, low_reg, shut_cfg_reg; // control
	logic [7:0] force_reg [2]; // fan force-on limits
	logic [7:0] release_reg [2]; // fan release limits
	logic [7:0] crit_reg [2]; // critical limits
	logic [7:0] fan_target_reg, fan_meas_reg, fan_health_reg; // fan registers
	temp_t temp_reg [2]; // latest results
	temp_t temp_in [2]; // converter inputs per channel
	conv_state_t conv_state; // scheduler state
	logic [28:0] conv_cnt, rate_cnt, rate_cycles; // scheduling counters
	logic pending_reg, start_now, conv_done; // scheduling events
	logic one_shot_wr, run_wr; // writes that start a conversion
	logic override_reg; // hysteresis fan force
	logic [4:0] fault_cnt [2]; // consecutive critical faults
	logic [4:0] fault_need; // faults needed to trip
	logic [7:0] status_flags, status_set; // sticky status bits
	logic status_rd; // status byte read
	logic alert_latch; // interrupt latch
	logic [7:0] meter_count; // count from reference domain
	logic meter_tgl, meter_stalled; // crossing signals
	logic [2:0] tgl_sh; // toggle synchroniser plus history
	logic [1:0] stall_sh; // stall level synchroniser
	logic [3:0] sat_run; // consecutive saturated counts
	logic fail_cond; // fan failure condition
	logic [7:0] speed_diff; // distance from target
	logic [10:0] diff_scaled; // distance times five

	// tach measurement in reference clock domain
	fan_tach_meter #(.STALL_CYCLES(STALL_CYCLES)) u_meter (
		.ref_clk(ref_clk),
		.srst(srst),
		.tach_input(tach_input),
		.count_out(meter_count),
		.count_tgl(meter_tgl),
		.stalled(meter_stalled)
	);

	// two-stage synchroniser for the bus, supply and diode fault pins
	assign pin_raw = {smb_clk_in, smb_data_in, supply_low, remote_diode_a_open,
		remote_diode_b_open, remote_diode_a_short, remote_diode_b_short};
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_meta <= 7'h60;
			pin_sync <= 7'h60;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			scl_d <= pin_sync[6];
			sda_d <= pin_sync[5];
		end
	end
	assign scl_s = pin_sync[6];
	assign sda_s = pin_sync[5];
	assign low_s = pin_sync[4];
	assign open_s = {pin_sync[2], pin_sync[3]};
	assign short_s = {pin_sync[0], pin_sync[1]};
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start_ev = scl_s && scl_d && sda_d && !sda_s;
	assign stop_ev = scl_s && scl_d && !sda_d && sda_s;

	// register read mux
	always_comb begin
		case (pointer_reg)
			`IDX_TEMP_A: rd_data = temp_reg[0];
			`IDX_TEMP_B: rd_data = temp_reg[1];
			`IDX_STATUS: rd_data = status_flags;
			`IDX_CONFIG: rd_data = config_reg;
			`IDX_CONV_RATE: rd_data = conv_rate_reg;
			`IDX_HIGH_LIM: rd_data = high_reg;
			`IDX_LOW_LIM: rd_data = low_reg;
			`IDX_FORCE_A: rd_data = force_reg[0];
			`IDX_RELEASE_A: rd_data = release_reg[0];
			`IDX_FORCE_B: rd_data = force_reg[1];
			`IDX_RELEASE_B: rd_data = release_reg[1];
			`IDX_CRIT_A: rd_data = crit_reg[0];
			`IDX_CRIT_B: rd_data = crit_reg[1];
			`IDX_SHUT_CFG: rd_data = shut_cfg_reg;
			`IDX_FAN_TARGET: rd_data = fan_target_reg;
			`IDX_FAN_MEAS: rd_data = fan_meas_reg;
			`IDX_FAN_HEALTH: rd_data = fan_health_reg;
			default: rd_data = 8'h00;
		endcase
	end
	assign tx_byte = ara_reg ? `ARA_REPLY : rd_data;

	// serial slave state machine
	always_ff @(posedge clk) begin
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		ara_stb <= 1'b0;
		if (srst) begin
			smb_state <= S_IDLE;
			bit_cnt <= 4'h0;
			shift_reg <= 8'h00;
			rw_reg <= 1'b0;
			ara_reg <= 1'b0;
			first_reg <= 1'b0;
			mack_reg <= 1'b0;
			drive_reg <= 1'b0;
			pointer_reg <= `RST_POINTER;
		end else if (start_ev) begin
			smb_state <= S_ADDR;
			bit_cnt <= 4'h0;
			drive_reg <= 1'b0;
			first_reg <= 1'b1;
		end else if (stop_ev) begin
			smb_state <= S_IDLE;
			drive_reg <= 1'b0;
		end else begin
			case (smb_state)
				// address byte, then match own or alert address
				S_ADDR: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						if (shift_reg[7:1] == `DEV_ADDR ||
							(shift_reg[7:1] == `ARA_ADDR && shift_reg[0])) begin
							smb_state <= S_ACK_ADDR;
							drive_reg <= 1'b1;
							rw_reg <= shift_reg[0];
							ara_reg <= (shift_reg[7:1] == `ARA_ADDR);
						end else begin
							smb_state <= S_IDLE;
						end
					end
				end
				// release acknowledge, start data phase
				S_ACK_ADDR: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (rw_reg) begin
							smb_state <= S_TX;
							shift_reg <= tx_byte;
							drive_reg <= ~tx_byte[7];
							rd_stb <= ~ara_reg;
							ara_stb <= ara_reg;
						end else begin
							smb_state <= S_RX;
							drive_reg <= 1'b0;
						end
					end
				end
				// received byte: pointer first, data after
				S_RX: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						smb_state <= S_ACK_RX;
						drive_reg <= 1'b1;
						first_reg <= 1'b0;
						if (first_reg)
							pointer_reg <= shift_reg;
						else
							wr_stb <= 1'b1;
					end
				end
				S_ACK_RX: begin
					if (scl_fall) begin
						smb_state <= S_RX;
						bit_cnt <= 4'h0;
						drive_reg <= 1'b0;
					end
				end
				// shift out, msb first
				S_TX: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h7) begin
							smb_state <= S_MACK;
							drive_reg <= 1'b0;
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
							shift_reg <= {shift_reg[6:0], 1'b0};
							drive_reg <= ~shift_reg[6];
						end
					end
				end
				// master acknowledge: repeat byte or finish
				S_MACK: begin
					if (scl_rise) begin
						mack_reg <= ~sda_s;
					end else if (scl_fall) begin
						if (mack_reg) begin
							smb_state <= S_TX;
							bit_cnt <= 4'h0;
							shift_reg <= tx_byte;
							drive_reg <= ~tx_byte[7];
							rd_stb <= ~ara_reg;
						end else begin
							smb_state <= S_IDLE;
						end
					end
				end
				default: smb_state <= S_IDLE;
			endcase
		end
	end
	assign smb_data_out = 1'b0;
	assign smb_data_oe_n = ~drive_reg;

	// software writable registers
	always_ff @(posedge clk) begin
		if (srst) begin
			config_reg <= `RST_CONFIG;
			conv_rate_reg <= `RST_CONV_RATE;
			high_reg <= `RST_HIGH_LIM;
			low_reg <= `RST_LOW_LIM;
			force_reg[0] <= `RST_FORCE;
			force_reg[1] <= `RST_FORCE;
			release_reg[0] <= `RST_RELEASE;
			release_reg[1] <= `RST_RELEASE;
			crit_reg[0] <= `RST_CRIT;
			crit_reg[1] <= `RST_CRIT;
			shut_cfg_reg <= `RST_SHUT_CFG;
			fan_target_reg <= `RST_FAN_TARGET;
		end else if (wr_stb) begin
			case (pointer_reg)
				`IDX_CONFIG: config_reg <= shift_reg;
				`IDX_CONV_RATE: conv_rate_reg <= shift_reg;
				`IDX_HIGH_LIM: high_reg <= shift_reg;
				`IDX_LOW_LIM: low_reg <= shift_reg;
				`IDX_FORCE_A: force_reg[0] <= shift_reg;
				`IDX_RELEASE_A: release_reg[0] <= shift_reg;
				`IDX_FORCE_B: force_reg[1] <= shift_reg;
				`IDX_RELEASE_B: release_reg[1] <= shift_reg;
				`IDX_CRIT_A: crit_reg[0] <= shift_reg;
				`IDX_CRIT_B: crit_reg[1] <= shift_reg;
				`IDX_SHUT_CFG: shut_cfg_reg <= shift_reg;
				`IDX_FAN_TARGET: fan_target_reg <= shift_reg;
				default: ;
			endcase
		end
	end
	assign fan_target_out = fan_target_reg;

	// conversion scheduler
	assign rate_cycles = 29'(RATE_BASE_CYCLES) >> conv_rate_reg[2:0];
	assign one_shot_wr = wr_stb && pointer_reg == `IDX_ONE_SHOT;
	assign run_wr = wr_stb && pointer_reg == `IDX_CONFIG &&
		config_reg[`CFG_STANDBY_BIT] && !shift_reg[`CFG_STANDBY_BIT];
	assign start_now = conv_state == CONV_IDLE && pending_reg && !low_s;
	assign conv_done = conv_state == CONV_RUN && conv_cnt == 29'(CONV_CYCLES - 1);
	always_ff @(posedge clk) begin
		if (srst) begin
			conv_state <= CONV_IDLE;
			conv_cnt <= 29'h0;
			rate_cnt <= 29'h0;
			pending_reg <= 1'b1;
			conv_start <= 1'b0;
		end else begin
			conv_start <= start_now;
			if (start_now)
				rate_cnt <= 29'h0;
			else if (rate_cnt < rate_cycles)
				rate_cnt <= rate_cnt + 29'h1;
			// a one-shot during a conversion is ignored
			if ((conv_state == CONV_IDLE && (one_shot_wr || run_wr)) ||
				// compare at or past the end: a faster rate may land after the timer passed it
				(!config_reg[`CFG_STANDBY_BIT] && !start_now && rate_cnt >= rate_cycles - 29'h1))
				pending_reg <= 1'b1;
			else if (start_now)
				pending_reg <= 1'b0;
			case (conv_state)
				CONV_IDLE: begin
					conv_cnt <= 29'h0;
					if (start_now)
						conv_state <= CONV_RUN;
				end
				CONV_RUN: begin
					conv_cnt <= conv_cnt + 29'h1;
					if (conv_done)
						conv_state <= CONV_IDLE;
				end
				default: conv_state <= CONV_IDLE;
			endcase
		end
	end
	assign conv_busy = conv_state == CONV_RUN;

	// capture results and fan override hysteresis
	assign temp_in[0] = remote_diode_a_temp;
	assign temp_in[1] = remote_diode_b_temp;
	always_ff @(posedge clk) begin
		if (srst) begin
			temp_reg[0] <= 8'sh00;
			temp_reg[1] <= 8'sh00;
			override_reg <= 1'b0;
			fan_supply_out <= 1'b0;
		end else begin
			if (conv_done) begin
				temp_reg[0] <= temp_in[0];
				temp_reg[1] <= temp_in[1];
				if (temp_in[0] > $signed(force_reg[0]) || temp_in[1] > $signed(force_reg[1]))
					override_reg <= 1'b1;
				else if (temp_in[0] < $signed(release_reg[0]) &&
					temp_in[1] < $signed(release_reg[1]))
					override_reg <= 1'b0;
			end
			fan_supply_out <= override_reg || (|open_s) || (&short_s);
		end
	end

	// per-channel consecutive critical fault counters
	assign fault_need = shut_cfg_reg[`SHUT_FILTER_BIT] ?
		({1'b0, shut_cfg_reg[3:0]} + 5'h01) : 5'h01;
	for (genvar ch = 0; ch < 2; ch++) begin : g_fault
		always_ff @(posedge clk) begin
			if (srst)
				fault_cnt[ch] <= 5'h00;
			else if (conv_done) begin
				if (temp_in[ch] < $signed(crit_reg[ch]))
					fault_cnt[ch] <= 5'h00;
				else if (fault_cnt[ch] < `FAULT_MAX)
					fault_cnt[ch] <= fault_cnt[ch] + 5'h01;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (srst)
			thermal_shutdown_out <= 1'b0;
		else
			thermal_shutdown_out <= fault_cnt[0] >= fault_need ||
				fault_cnt[1] >= fault_need;
	end

	// fan measurement crossing and failure detection
	always_ff @(posedge clk) begin
		if (srst) begin
			tgl_sh <= 3'h0;
			stall_sh <= 2'h0;
			fan_meas_reg <= `RST_FAN_MEAS;
			sat_run <= 4'h0;
		end else begin
			tgl_sh <= {tgl_sh[1:0], meter_tgl};
			stall_sh <= {stall_sh[0], meter_stalled};
			if (tgl_sh[2] != tgl_sh[1]) begin
				fan_meas_reg <= meter_count;
				if (meter_count != `TACH_SAT)
					sat_run <= 4'h0;
				else if (sat_run < `SAT_RUN_LIMIT)
					sat_run <= sat_run + 4'h1;
			end
		end
	end
	assign fail_cond = config_reg[`CFG_DETECT_BIT] &&
		(stall_sh[1] || sat_run == `SAT_RUN_LIMIT);

	// fan health flags
	assign speed_diff = (fan_meas_reg > fan_target_reg) ?
		fan_meas_reg - fan_target_reg : fan_target_reg - fan_meas_reg;
	assign diff_scaled = 11'(speed_diff) * 11'(`OFF_TARGET_MUL);
	always_ff @(posedge clk) begin
		if (srst)
			fan_health_reg <= `RST_FAN_HEALTH;
		else begin
			fan_health_reg <= 8'h00;
			fan_health_reg[`HEALTH_OFF] <= diff_scaled > 11'(fan_target_reg);
			fan_health_reg[`HEALTH_SLOW] <= fan_meas_reg == `TACH_SAT;
		end
	end

	// sticky status bits 6:2 and 0, bit 1 held at zero, live busy bit 7, set wins over read clear
	assign status_rd = rd_stb && pointer_reg == `IDX_STATUS;
	always_comb begin
		status_set = 8'h00;
		status_set[`ST_FAN_FAIL] = fail_cond;
		status_set[`ST_OPEN] = start_now && (|open_s);
		status_set[`ST_HIGH_A] = conv_done && temp_in[0] > $signed(high_reg);
		status_set[`ST_LOW_A] = conv_done && temp_in[0] < $signed(low_reg);
		status_set[`ST_HIGH_B] = conv_done && temp_in[1] > $signed(high_reg);
		status_set[`ST_LOW_B] = conv_done && temp_in[1] < $signed(low_reg);
	end
	always_ff @(posedge clk) begin
		if (srst)
			status_flags <= 8'h00;
		else begin
			status_flags[6:0] <= ((status_rd ? 7'h00 : status_flags[6:0]) |
				status_set[6:0]) & 7'h7d;
			status_flags[`ST_BUSY] <= conv_state == CONV_RUN;
		end
	end

	// interrupt latch drives the alert pin
	always_ff @(posedge clk) begin
		if (srst)
			alert_latch <= 1'b0;
		else if (fail_cond || (|status_set[6:3]))
			alert_latch <= 1'b1;
		else if (ara_stb)
			alert_latch <= 1'b0;
	end
	assign alert_out = 1'b0;
	assign alert_oe_n = ~alert_latch;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_conv_begin;
		conv_start;
	endsequence
	sequence s_busy_hold;
		conv_busy [*8];
	endsequence
	a_conv_busy_run: assert property (s_conv_begin |-> s_busy_hold)
		else $error("conversion ended too early");
	a_uvlo_no_start: assert property (low_s |=> !conv_start)
		else $error("conversion started under low supply");
	a_ack_drive: assert property ((smb_state == S_ACK_ADDR || smb_state == S_ACK_RX)
		|-> !smb_data_oe_n)
		else $error("acknowledge not driven");
	a_override_hold: assert property (override_reg && !conv_done |=> override_reg)
		else $error("fan override dropped between conversions");
	a_diode_force: assert property ((|open_s) || (&short_s) |=> fan_supply_out)
		else $error("fan not forced on diode fault");
	a_slow_flag: assert property (fan_meas_reg == `TACH_SAT |=> fan_health_reg[1])
		else $error("slow fan flag missing");
	a_detect_gate: assert property (!config_reg[`CFG_DETECT_BIT] && !status_flags[0]
		|=> !status_flags[0])
		else $error("fan fail flagged while detection disabled");
	a_alert_fail: assert property (fail_cond |=> !alert_oe_n && status_flags[0])
		else $error("fan failure did not raise alert");
	a_sticky_hold: assert property (status_flags[0] && !status_rd |=> status_flags[0])
		else $error("fan fail flag cleared without read");
	a_shutdown_trip: assert property (fault_cnt[0] >= fault_need |=> thermal_shutdown_out)
		else $error("thermal shutdown not asserted");
endmodule // thermal_fan_supervisor

// >>> tb/smb_host_model.sv
`timescale 1ns/1ps
module smb_host_model (
	// bus pins
	output logic scl,
	output logic sda,
	input wire logic sda_line,
	// read result
	output logic [7:0] rd_data,
	output logic rd_valid
);
	initial begin
		scl = 1;
		sda = 1;
		rd_valid = 0;
		rd_data = 0;
	end
	// data moves only while the clock is low, sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		sda = b;
		#400 scl = 1;
		#400 r = sda_line;
		scl = 0;
	endtask
	// nine bits, msb first, ninth is the acknowledge slot
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
			bit_io(tx[i], rx[i]);
	endtask
	task automatic start();
		#400 sda = 0;
		#400 scl = 0;
	endtask
	task automatic stop();
		sda = 0;
		#400 scl = 1;
		#400 sda = 1;
		#400;
	endtask
	// write byte: address, pointer, data
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic ack);
		logic [8:0] a, b, c;
		start();
		xfer({8'h7a, 1'b1}, a);
		xfer({idx, 1'b1}, b);
		xfer({d, 1'b1}, c);
		stop();
		ack = a[0] | b[0] | c[0];
	endtask
	// send byte sets the pointer, then a receive byte ended by a nack
	task automatic rd(input logic [7:0] idx, output logic ack);
		logic [8:0] a, b, c;
		start();
		xfer({8'h7a, 1'b1}, a);
		xfer({idx, 1'b1}, b);
		stop();
		start();
		xfer({8'h7b, 1'b1}, c);
		ack = a[0] | b[0] | c[0];
		xfer(9'h1ff, a);
		stop();
		rd_data = a[8:1];
		rd_valid = 1;
		#40 rd_valid = 0;
	endtask
	// alert response read: the reply byte names the device
	task automatic ara(output logic ack);
		logic [8:0] a, c;
		start();
		xfer({8'h19, 1'b1}, c);
		ack = c[0];
		xfer(9'h1ff, a);
		stop();
		rd_data = a[8:1];
		rd_valid = 1;
		#40 rd_valid = 0;
	endtask
endmodule // smb_host_model

// >>> tb/test_thermal_fan_supervisor.sv
`timescale 1ns/1ps
module test_thermal_fan_supervisor;
	import thermal_fan_pkg::*;
	logic clk = 0, ref_clk = 0, srst = 1, supply_low = 0, a_open = 0;
	logic a_short = 0, b_short = 0, tach = 0, tach_run = 0;
	temp_t ta = 0, tb = 0;
	logic scl, sda, sda_line, dout, oe_n, rd_valid, cs, busy, fan, shut, alert_n, ara_ack;
	logic [7:0] rd_data, tgt, r;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h00003a79;
	temp_t tv[6] = '{8'sh46, 8'sh47, 8'sh3c, 8'sh3b, 8'sh00, 8'sh00};
	temp_t tw[6] = '{8'sh00, 8'sh00, 8'sh00, 8'sh00, 8'sh47, 8'sh3b};
	logic [7:0] fv[6] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00};
	int errors = 0, checked = 0, cyc = 0, n;
	// system clock and unrelated fan reference clock
	initial forever #20 clk = ~clk;
	initial begin
		#7;
		forever #80 ref_clk = ~ref_clk;
	end
	// fan pulses while enabled: a level change every 32 clocks, just after the edge
	initial begin
		#21;
		forever #1280 if (tach_run) tach = ~tach;
	end
	// data line with pull-up, low when any party pulls
	assign sda_line = sda & (oe_n | dout);
	thermal_fan_supervisor #(.CONV_CYCLES(20), .RATE_BASE_CYCLES(1024), .STALL_CYCLES(600)) dut (
		.clk(clk), .srst(srst), .ref_clk(ref_clk), .smb_clk_in(scl), .smb_data_in(sda_line),
		.smb_data_out(dout), .smb_data_oe_n(oe_n), .alert_out(), .alert_oe_n(alert_n),
		.conv_start(cs), .conv_busy(busy), .remote_diode_a_temp(ta), .remote_diode_b_temp(tb),
		.supply_low(supply_low), .remote_diode_a_open(a_open), .remote_diode_b_open(1'b0),
		.remote_diode_a_short(a_short), .remote_diode_b_short(b_short), .tach_input(tach),
		.fan_target_out(tgt), .fan_supply_out(fan), .thermal_shutdown_out(shut));
	smb_host_model host (.scl(scl), .sda(sda), .sda_line(sda_line), .rd_data(rd_data),
		.rd_valid(rd_valid));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checked++;
		if (seen !== want) begin
			errors++;
			$display("[FAIL] %0t: got %h expected %h", $time, seen, want);
		end
	endtask
	task automatic results();
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	// read notes its expectation; the monitor compares
	task automatic rd(input logic [7:0] idx, input logic [7:0] want);
		logic ack;
		exp_q.push_back(want);
		host.rd(idx, ack);
		check({7'h00, ack}, 8'h00);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic ack;
		host.wr(idx, d, ack);
		check({7'h00, ack}, 8'h00);
	endtask
	task automatic next_start();
		do
			tick();
		while (cs !== 1'b1);
	endtask
	// wait out one whole conversion begun after the call
	task automatic conv_end();
		next_start();
		@(negedge busy);
		repeat (2) tick();
	endtask
	// compare each read result against the oldest expectation
	always @(posedge rd_valid) check(rd_data, exp_q.pop_front());
	// cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			results();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 srst = 0;
		rd(8'h10, 8'hff);
		rd(8'h11, 8'hff);
		rd(8'h12, 8'h02);
		rd(8'h04, 8'h02);
		rd(8'h13, 8'h00);
		seed = xs(seed);
		r = seed[7:0];
		wr(8'h10, r);
		wr(8'h11, ~r);
		rd(8'h10, r);
		rd(8'h11, 8'hff);
		check(tgt, r);
		// upper rate bits set; low bits give 1024 >> 3 cycles
		wr(8'h04, 8'hfb);
		next_start();
		next_start();
		n = 0;
		do begin
			tick();
			n++;
		end while (cs !== 1'b1 && n < 400);
		check({7'h00, n >= 96 && n <= 160}, 8'h01);
		// at the force-on limit, above it, at and below the release limit
		foreach (tv[i]) begin
			tick();
			ta = tv[i];
			tb = tw[i];
			conv_end();
			check({7'h00, fan}, fv[i]);
		end
		tick();
		a_open = 1;
		repeat (5) tick();
		check({7'h00, fan}, 8'h01);
		a_open = 0;
		// one shorted diode alone does not force the fan, both do
		a_short = 1;
		repeat (5) tick();
		check({7'h00, fan}, 8'h00);
		b_short = 1;
		repeat (5) tick();
		check({7'h00, fan}, 8'h01);
		a_short = 0;
		b_short = 0;
		// default filter needs three faults in a row
		ta = 8'sh7f;
		for (int i = 1; i <= 3; i++) begin
			conv_end();
			check({7'h00, shut}, {7'h00, i == 3});
		end
		ta = 8'sh00;
		conv_end();
		wr(8'h0d, 8'h02);
		tick();
		ta = 8'sh7f;
		conv_end();
		check({7'h00, shut}, 8'h01);
		// stalled tach raises no alert until detection is enabled
		check({7'h00, alert_n}, 8'h01);
		wr(8'h03, 8'h20);
		check({7'h00, alert_n}, 8'h00);
		// host drops detection, then the alert reply clears the pin
		wr(8'h03, 8'h00);
		exp_q.push_back(8'h7a);
		host.ara(ara_ack);
		check({7'h00, ara_ack}, 8'h00);
		check({7'h00, alert_n}, 8'h01);
		// steady pulses, 16 reference periods a turn
		tach_run = 1;
		repeat (200) tick();
		rd(8'h11, 8'h10);
		rd(8'h12, {7'h00, 80 > 6 * r || 80 < 4 * r});
		// undervoltage holds off every start
		supply_low = 1;
		repeat (5) tick();
		n = 0;
		repeat (300) begin
			tick();
			if (cs === 1'b1)
				n++;
		end
		check(n[7:0], 8'h00);
		results();
	end
endmodule // test_thermal_fan_supervisor
